// *** logic/dva_control.v ***
// Control logic for a DisplayPort to VGA adapter: straps, DDC speed, HPD, video path.
// Assumes synchronous pixel data already recovered on clk; straps and resets from pins.
`timescale 1ns/1ns
`include "dva_regs.vh"
module dva_control #(
	parameter IRQ_PULSE_CYC = `DVA_IRQ_PULSE_CYC
) (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Straps and monitor sense (pins)
	input wire hotplug_policy_strap,
	input wire ddc_speed_strap,
	input wire monitor_sense,
	// Recovered main stream
	input wire link_valid,
	input wire [2:0] bpc_sel,
	input wire [15:0] pix_red,
	input wire [15:0] pix_grn,
	input wire [15:0] pix_blu,
	input wire pix_hsync,
	input wire pix_vsync,
	// AUX request classification
	input wire aux_req,
	input wire aux_is_i2c,
	// Avalon-MM slave
	input wire [5:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	// Video outputs
	output reg [7:0] dac_red,
	output reg [7:0] dac_grn,
	output reg [7:0] dac_blu,
	output reg vga_hsync,
	output reg vga_vsync,
	output reg dac_power_on,
	// Source-facing
	output reg hpd,
	output reg hpd_irq_pulse,
	output reg [7:0] ddc_speed,
	output reg aux_native_sel,
	output reg aux_i2c_bridge,
	output reg irq
);
	// ========================================
	// Input synchronisers
	reg [1:0] pol_sync_r;
	reg [1:0] spd_sync_r;
	reg [1:0] mon_sync_r;
	// Two stages before any reader; first stage feeds only the second
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pol_sync_r <= 2'h0;
			spd_sync_r <= 2'h0;
			mon_sync_r <= 2'h0;
		end else begin
			pol_sync_r <= {pol_sync_r[0], hotplug_policy_strap};
			spd_sync_r <= {spd_sync_r[0], ddc_speed_strap};
			mon_sync_r <= {mon_sync_r[0], monitor_sense};
		end
	end
	wire policy_s = pol_sync_r[1];
	wire mon_s = mon_sync_r[1];

	// ========================================
	// Strap capture after reset release
	reg strap_done_r;
	reg policy_r;
	reg spd_strap_r;
	reg [1:0] settle_r;
	// Wait for the synchroniser to fill before sampling straps
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			settle_r <= 2'h0;
			strap_done_r <= 1'b0;
			policy_r <= 1'b0;
			spd_strap_r <= 1'b0;
		end else if (!strap_done_r) begin
			settle_r <= settle_r + 2'h1;
			if (settle_r == 2'h3) begin
				strap_done_r <= 1'b1;
				policy_r <= policy_s;
				spd_strap_r <= spd_sync_r[1];
			end
		end
	end

	// ========================================
	// Registers
	reg [7:0] ctrl_r;
	reg [7:0] irq_mask_r;
	reg [7:0] irq_stat_r;
	reg [7:0] link_cfg_r;
	reg mon_prev_r;
	reg link_prev_r;
	reg [7:0] spd_nxt;
	reg [7:0] masked;

	wire wr_hit = avs_write && !avs_waitrequest;
	wire rd_hit = avs_read && !avs_waitrequest;
	wire [7:0] wr_byte = avs_writedata[7:0];
	wire wr_b0 = avs_byteenable[0];

	// Slowest speed in mask AND capability; none keeps the old one
	always @* begin
		masked = wr_byte & `DVA_DDC_CAP_VAL;
		spd_nxt = ddc_speed;
		if (masked[0])
			spd_nxt = `DVA_SPD_1K;
		else if (masked[1])
			spd_nxt = `DVA_SPD_3K;
		else if (masked[2])
			spd_nxt = `DVA_SPD_10K;
		else if (masked[7])
			spd_nxt = `DVA_SPD_50K;
		else if (masked[3])
			spd_nxt = `DVA_SPD_100K;
	end

	// Monitor presence: detected pin or, in standard mode, software view
	wire mon_now = policy_r ? mon_s : ctrl_r[`DVA_CTRL_MON_PRESENT];
	wire mon_edge = strap_done_r && (mon_now != mon_prev_r);
	wire link_lost = link_prev_r && !link_valid;
	wire spd_wr = wr_hit && wr_b0 && (avs_address == `DVA_OFF_DDC_SPEED);

	// Control and config writes, default DDC speed from strap
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_r <= `DVA_CTRL_RST;
			irq_mask_r <= `DVA_MASK_RST;
			link_cfg_r <= `DVA_LINK_RST;
			ddc_speed <= `DVA_SPD_50K;
		end else begin
			if (!strap_done_r)
				ddc_speed <= spd_sync_r[1] ? `DVA_SPD_10K : `DVA_SPD_50K;
			else if (spd_wr)
				ddc_speed <= spd_nxt;
			if (wr_hit && wr_b0 && avs_address == `DVA_OFF_CTRL)
				ctrl_r <= wr_byte;
			if (wr_hit && wr_b0 && avs_address == `DVA_OFF_IRQ_MASK)
				irq_mask_r <= wr_byte;
			// Lane count and rate; both rates and widths accepted
			if (wr_hit && wr_b0 && avs_address == `DVA_OFF_LINK_CFG)
				link_cfg_r <= {6'h00, wr_byte[1:0]};
		end
	end

	// ========================================
	// Sticky interrupt status; a set in the clearing read wins
	reg [7:0] ev;
	always @* begin
		ev = 8'h00;
		ev[`DVA_IRQ_MON_CHANGE] = mon_edge;
		ev[`DVA_IRQ_SPEED_CHANGE] = spd_wr && (spd_nxt != ddc_speed);
		ev[`DVA_IRQ_LINK_LOST] = link_lost;
	end
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_stat_r <= 8'h00;
			irq <= 1'b0;
		end else begin
			if (rd_hit && avs_address == `DVA_OFF_IRQ_STAT)
				irq_stat_r <= ev;
			else
				irq_stat_r <= irq_stat_r | ev;
			irq <= |(((rd_hit && avs_address == `DVA_OFF_IRQ_STAT) ? ev
				: (irq_stat_r | ev)) & irq_mask_r);
		end
	end

	// ========================================
	// HPD and HPD interrupt pulse
	reg [15:0] pulse_cnt_r;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hpd <= 1'b0;
			hpd_irq_pulse <= 1'b0;
			pulse_cnt_r <= 16'h0000;
			mon_prev_r <= 1'b0;
			link_prev_r <= 1'b0;
		end else begin
			mon_prev_r <= strap_done_r ? mon_now : mon_prev_r;
			link_prev_r <= link_valid;
			if (!strap_done_r)
				hpd <= 1'b0;
			else if (policy_r)
				hpd <= mon_now;
			else
				hpd <= ctrl_r[`DVA_CTRL_HPD_STD];
			// Pulse on every attach and detach; a new change restarts the count
			if (mon_edge) begin
				pulse_cnt_r <= IRQ_PULSE_CYC[15:0];
				hpd_irq_pulse <= 1'b1;
			end else if (pulse_cnt_r > 16'h0001) begin
				pulse_cnt_r <= pulse_cnt_r - 16'h0001;
			end else begin
				pulse_cnt_r <= 16'h0000;
				hpd_irq_pulse <= 1'b0;
			end
		end
	end

	// ========================================
	// AUX request steering
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aux_native_sel <= 1'b0;
			aux_i2c_bridge <= 1'b0;
		end else begin
			aux_native_sel <= aux_req && !aux_is_i2c;
			aux_i2c_bridge <= aux_req && aux_is_i2c;
		end
	end

	// ========================================
	// Colour truncation and sync, one register stage for all
	function [7:0] dva_trunc;
		input [15:0] c;
		input [2:0] bpc;
		begin
			case (bpc)
				3'h0: dva_trunc = {c[5:0], 2'h0};
				3'h1: dva_trunc = c[7:0];
				3'h2: dva_trunc = c[9:2];
				3'h3: dva_trunc = c[11:4];
				3'h4: dva_trunc = c[15:8];
				default: dva_trunc = c[7:0];
			endcase
		end
	endfunction
	// Blanked to zero when the link is down so the DAC idles dark
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dac_red <= 8'h00;
			dac_grn <= 8'h00;
			dac_blu <= 8'h00;
			vga_hsync <= 1'b0;
			vga_vsync <= 1'b0;
			dac_power_on <= 1'b0;
		end else begin
			dac_power_on <= link_valid;
			dac_red <= link_valid ? dva_trunc(pix_red, bpc_sel) : 8'h00;
			dac_grn <= link_valid ? dva_trunc(pix_grn, bpc_sel) : 8'h00;
			dac_blu <= link_valid ? dva_trunc(pix_blu, bpc_sel) : 8'h00;
			vga_hsync <= link_valid & pix_hsync;
			vga_vsync <= link_valid & pix_vsync;
		end
	end

	// ========================================
	// Avalon slave: one wait cycle, then answer
	reg [7:0] rd_byte;
	always @* begin
		case (avs_address)
			`DVA_OFF_CTRL: rd_byte = ctrl_r;
			`DVA_OFF_STAT: rd_byte = {2'h0, link_valid, spd_strap_r, policy_r,
				dac_power_on, mon_now, hpd};
			`DVA_OFF_IRQ_STAT: rd_byte = irq_stat_r;
			`DVA_OFF_IRQ_MASK: rd_byte = irq_mask_r;
			`DVA_OFF_DDC_CAP: rd_byte = `DVA_DDC_CAP_VAL;
			`DVA_OFF_DDC_SPEED: rd_byte = ddc_speed;
			`DVA_OFF_LINK_CFG: rd_byte = link_cfg_r;
			default: rd_byte = 8'h00;
		endcase
	end
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
		end else begin
			if ((avs_read || avs_write) && avs_waitrequest) begin
				avs_waitrequest <= 1'b0;
				avs_readdata <= {24'h000000, rd_byte};
			end else begin
				avs_waitrequest <= 1'b1;
			end
		end
	end
endmodule

// *** logic/dva_regs.vh ***
// Constants for the adapter control block: register offsets, fields, reset values, timing.
// Assumes a 32-bit Avalon-MM slave with byte addresses and one aligned word per register.
`ifndef DVA_REGS_VH
`define DVA_REGS_VH
// ========================================
// Register byte offsets
`define DVA_OFF_CTRL 6'h00
`define DVA_OFF_STAT 6'h04
`define DVA_OFF_IRQ_STAT 6'h08
`define DVA_OFF_IRQ_MASK 6'h0c
`define DVA_OFF_DDC_CAP 6'h10
`define DVA_OFF_DDC_SPEED 6'h14
`define DVA_OFF_LINK_CFG 6'h18
// ========================================
// Control fields
`define DVA_CTRL_AUX_NATIVE 0
`define DVA_CTRL_AUX_I2C 1
`define DVA_CTRL_MON_PRESENT 2
`define DVA_CTRL_HPD_STD 3
// Status fields
`define DVA_STAT_HPD 0
`define DVA_STAT_MON 1
`define DVA_STAT_VIDEO_ON 2
`define DVA_STAT_POLICY 3
`define DVA_STAT_SPEED_STRAP 4
`define DVA_STAT_LINK_OK 5
// Interrupt fields
`define DVA_IRQ_MON_CHANGE 0
`define DVA_IRQ_SPEED_CHANGE 1
`define DVA_IRQ_LINK_LOST 2
// ========================================
// DDC speed one-hot codes
`define DVA_SPD_1K 8'h01
`define DVA_SPD_3K 8'h02
`define DVA_SPD_10K 8'h04
`define DVA_SPD_100K 8'h08
`define DVA_SPD_50K 8'h80
`define DVA_DDC_CAP_VAL 8'h8f
// Reset values
`define DVA_CTRL_RST 8'h00
`define DVA_MASK_RST 8'h00
`define DVA_LINK_RST 8'h00
// Link config fields: lane count and rate select
`define DVA_LINK_TWO_LANE 0
`define DVA_LINK_HBR 1
// ========================================
// Timing: HPD interrupt pulse, in ns, at 50 ns clock
`define DVA_CLK_NS 50
`define DVA_IRQ_PULSE_NS 750000
`define DVA_IRQ_PULSE_CYC ((`DVA_IRQ_PULSE_NS + `DVA_CLK_NS - 1) / `DVA_CLK_NS)
// Main link rates, kbit/s per lane
`define DVA_RATE_HBR_KBPS 2700000
`define DVA_RATE_RBR_KBPS 1620000
// Pixel clock ceiling in MHz
`define DVA_PIX_MAX_MHZ 240
`endif

// *** test/dva_src_model.sv ***
// Stream source model: random pixels, colour depths, syncs, link validity, AUX requests.
// Assumes the bench clock; outputs change just after each rising edge.
`timescale 1ns/1ns
module dva_src_model (
	// Clock
	input wire clk,
	// Main stream towards the adapter
	output reg link_valid,
	output reg [2:0] bpc_sel,
	output reg [15:0] pix_red,
	output reg [15:0] pix_grn,
	output reg [15:0] pix_blu,
	output reg pix_hsync,
	output reg pix_vsync,
	// AUX request class
	output reg aux_req,
	output reg aux_is_i2c
);
	integer seed = 32'h1e45;
	reg [31:0] rv;
	// New pixel each cycle; link drops now and then to exercise power-down
	always @(posedge clk) begin
		rv = $random(seed);
		link_valid <= rv[2:0] != 3'h0;
		bpc_sel <= rv[5:3] > 3'h4 ? 3'h7 : rv[5:3];
		{pix_hsync, pix_vsync, aux_req, aux_is_i2c} <= rv[9:6];
		pix_blu <= rv[31:16];
		{pix_red, pix_grn} <= $random(seed);
	end
endmodule

// *** test/dva_control_props.sv ***
// Checker: video path, bus wait state, HPD follow and interrupt pulse length.
// Assumes one clock and the async active-low reset of the top module.
`timescale 1ns/1ns
module dva_control_props #(
	parameter IRQ_PULSE_CYC = 15000
) (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Watched inputs
	input wire hotplug_policy_strap,
	input wire monitor_sense,
	input wire link_valid,
	input wire [2:0] bpc_sel,
	input wire [15:0] pix_red,
	input wire pix_hsync,
	input wire pix_vsync,
	input wire avs_read,
	input wire avs_write,
	// Watched outputs
	input wire avs_waitrequest,
	input wire [7:0] dac_red,
	input wire [7:0] dac_grn,
	input wire [7:0] dac_blu,
	input wire vga_hsync,
	input wire vga_vsync,
	input wire dac_power_on,
	input wire hpd,
	input wire hpd_irq_pulse
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	reg [15:0] hi_cnt_r;
	// Pulse length counter; a counter keeps the repetition small
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			hi_cnt_r <= 16'h0000;
		else
			hi_cnt_r <= hpd_irq_pulse ? hi_cnt_r + 16'h0001 : 16'h0000;
	end
	sequence s_bus_ack;
		(avs_read || avs_write) && avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	// ==========================================
	// Properties
	chk_bus_one_wait: assert property (s_bus_ack |=> avs_waitrequest)
		else $error("wait state not one cycle");
	chk_dark_idle: assert property (!link_valid |=> !dac_power_on && dac_red == 8'h00
		&& dac_grn == 8'h00 && dac_blu == 8'h00) else $error("video not dark");
	chk_trunc_wide: assert property (link_valid && bpc_sel == 3'h4 |=> dac_red == $past(pix_red[15:8]))
		else $error("wide colour not truncated");
	chk_pass_eight: assert property (link_valid && bpc_sel == 3'h1 |=> dac_red == $past(pix_red[7:0]))
		else $error("8 bit colour altered");
	chk_sync_same: assert property (link_valid |=> vga_hsync == $past(pix_hsync)
		&& vga_vsync == $past(pix_vsync) && dac_power_on) else $error("sync misaligned");
	chk_pulse_len: assert property ($fell(hpd_irq_pulse) |-> hi_cnt_r == IRQ_PULSE_CYC)
		else $error("irq pulse length wrong");
	chk_hpd_attach: assert property ((hotplug_policy_strap && monitor_sense) [*6] |=> hpd)
		else $error("hpd not raised");
	chk_hpd_detach: assert property ((hotplug_policy_strap && !monitor_sense) [*6] |=> !hpd)
		else $error("hpd not lowered");
	chk_pulse_on_hpd: assert property ($changed(hpd) && hotplug_policy_strap
		|-> hpd_irq_pulse) else $error("no irq pulse on monitor change");
endmodule
bind dva_control dva_control_props #(.IRQ_PULSE_CYC(IRQ_PULSE_CYC)) dva_control_props_i (
	.clk(clk),
	.reset_n(reset_n),
	.hotplug_policy_strap(hotplug_policy_strap),
	.monitor_sense(monitor_sense),
	.link_valid(link_valid),
	.bpc_sel(bpc_sel),
	.pix_red(pix_red),
	.pix_hsync(pix_hsync),
	.pix_vsync(pix_vsync),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest),
	.dac_red(dac_red),
	.dac_grn(dac_grn),
	.dac_blu(dac_blu),
	.vga_hsync(vga_hsync),
	.vga_vsync(vga_vsync),
	.dac_power_on(dac_power_on),
	.hpd(hpd),
	.hpd_irq_pulse(hpd_irq_pulse)
);

// *** test/dva_control_bench.sv ***
// Bench for the adapter control block: registers, straps, HPD, video path.
// Assumes the bound checker and the stream source model.
`timescale 1ns/1ns
module dva_control_bench;
	reg clk = 1'b0, reset_n = 1'b0, hotplug_policy_strap = 1'b0;
	reg ddc_speed_strap = 1'b0, monitor_sense = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	reg [5:0] avs_address = 6'h00;
	reg [31:0] avs_writedata = 32'h0;
	reg [3:0] avs_byteenable = 4'hf;
	wire link_valid, pix_hsync, pix_vsync, aux_req, aux_is_i2c, aux_native_sel, aux_i2c_bridge;
	wire avs_waitrequest, vga_hsync, vga_vsync, dac_power_on, hpd, hpd_irq_pulse, irq;
	wire [2:0] bpc_sel;
	wire [15:0] pix_red, pix_grn, pix_blu;
	wire [31:0] avs_readdata;
	wire [7:0] dac_red, dac_grn, dac_blu, ddc_speed;
	integer num_errors = 0, check_count = 0, n;
	reg [31:0] rq[$], mq[$], vq[$];
	always #25 clk = ~clk;
	dva_src_model dva_src_model_i (.*);
	dva_control #(.IRQ_PULSE_CYC(4)) dva_control_i (.*);
	// ==========================================
	// Helpers
	task chk(input string nm, input [31:0] e, input [31:0] g);
		check_count = check_count + 1;
		if (g !== e) begin
			num_errors = num_errors + 1;
			$display("[FAIL] %0s expected %h seen %h", nm, e, g);
		end
	endtask
	function [7:0] tr(input [15:0] c, input [2:0] b);
		case (b)
			3'h0: tr = {c[5:0], 2'b00};
			3'h2: tr = c[9:2];
			3'h3: tr = c[11:4];
			3'h4: tr = c[15:8];
			default: tr = c[7:0];
		endcase
	endfunction
	// Bus access held until waitrequest low; reads note their expectation
	task acc(input w, input [5:0] a, input [31:0] d, input [31:0] m);
		@(posedge clk);
		{avs_address, avs_writedata, avs_write, avs_read} <= {a, d, w, !w};
		if (!w) begin
			rq.push_back(d);
			mq.push_back(m);
		end
		@(posedge clk);
		// No cycle count assumed; only the watchdog ends a hung access
		while (avs_waitrequest !== 1'b0)
			@(posedge clk);
		{avs_write, avs_read} <= 2'b00;
	endtask
	task ws(input s, input v);
		n = 0;
		while ((s ? irq : hpd) !== v && n < 40) begin
			@(posedge clk);
			n = n + 1;
		end
		chk(s ? "irq" : "hpd", v, s ? irq : hpd);
	endtask
	task sp(input [7:0] m, input [7:0] e);
		acc(1, 6'h14, m, 0);
		acc(0, 6'h14, e, 32'hff);
		chk("ddc_speed", e, ddc_speed);
	endtask
	task close_out;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Read results compared at the accepting edge
	always @(posedge clk) if (avs_read && avs_waitrequest === 1'b0 && rq.size() > 0) begin
		chk("readdata", rq[0] & mq[0], avs_readdata & mq[0]);
		rq.delete(0);
		mq.delete(0);
	end
	// Video noted from the sampled inputs, compared one edge later
	always @(posedge clk) if (!reset_n) vq.delete(); else begin
		if (vq.size() > 0)
			chk("video", vq.pop_front(), {aux_native_sel, aux_i2c_bridge, dac_power_on, vga_hsync,
				vga_vsync, dac_red, dac_grn, dac_blu});
		vq.push_back({aux_req && !aux_is_i2c, aux_req && aux_is_i2c,
			link_valid ? {1'b1, pix_hsync, pix_vsync, tr(pix_red, bpc_sel),
			tr(pix_grn, bpc_sel), tr(pix_blu, bpc_sel)} : 27'h0});
	end
	// Watchdog well beyond the expected run length
	initial begin
		#1000000;
		num_errors = num_errors + 1;
		close_out;
	end
	// ==========================================
	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		repeat (6) @(posedge clk);
		chk("ddc_speed", 8'h80, ddc_speed);
		acc(0, 6'h10, 8'h8f, 32'hffffffff);
		acc(0, 6'h20, 0, 32'hffffffff);
		acc(1, 6'h18, 3, 0);
		acc(0, 6'h18, 3, 32'hff);
		sp(8'hff, 8'h01);
		sp(8'h0c, 8'h04);
		sp(8'h30, 8'h04);
		sp(8'h80, 8'h80);
		avs_byteenable <= 4'h0;
		sp(8'h01, 8'h80);
		avs_byteenable <= 4'hf;
		acc(0, 6'h04, 0, 32'h18);
		acc(1, 6'h00, 8, 0);
		ws(0, 1);
		acc(1, 6'h00, 0, 0);
		ws(0, 0);
		// Second reset, both straps high
		{reset_n, hotplug_policy_strap, ddc_speed_strap} <= 3'b011;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		repeat (6) @(posedge clk);
		chk("ddc_speed", 8'h04, ddc_speed);
		acc(1, 6'h0c, 1, 0);
		monitor_sense <= 1'b1;
		ws(0, 1);
		acc(0, 6'h08, 1, 1);
		monitor_sense <= 1'b0;
		// Let the level from before the clearing read pass first
		@(posedge clk);
		ws(1, 1);
		ws(0, 0);
		acc(0, 6'h08, 1, 1);
		repeat (2) @(posedge clk);
		ws(1, 0);
		close_out;
	end
endmodule
